// File: core/plldc_pkg.sv
// Package of offsets, fields, reset values and timing for the lock detector
package plldc_pkg;

  // Register offsets on the device register port
  localparam logic [9:0] OFF_LOCK_CFG = 10'h018;
  localparam logic [9:0] OFF_SYNC_DLY = 10'h019;
  localparam logic [9:0] OFF_STAT_MON = 10'h01A;
  localparam logic [9:0] OFF_STATUS   = 10'h01F;

  // Field positions in the lock detect configuration register
  localparam int unsigned LCK_DCOFS_BIT = 7;
  localparam int unsigned LCK_CNT_LSB   = 5;
  localparam int unsigned LCK_WIN_BIT   = 4;
  localparam int unsigned LCK_DIS_BIT   = 3;

  // Field positions in the sync and path delay register
  localparam int unsigned SYNC_MODE_LSB = 6;
  localparam int unsigned RDLY_LSB      = 3;
  localparam int unsigned NDLY_LSB      = 0;

  // Field positions in the status divider and monitor register
  localparam int unsigned STDIV_BIT     = 7;
  localparam int unsigned RMON_THR_BIT  = 6;

  // Field positions in the read-only status register
  localparam int unsigned ST_LOCK_BIT   = 0;
  localparam int unsigned ST_REFERENCE_INPUT_ONE_BIT   = 1;
  localparam int unsigned ST_REFERENCE_INPUT_TWO_BIT   = 2;
  localparam int unsigned ST_CLK_BIT    = 3;
  localparam int unsigned ST_SYNC_BIT   = 4;

  // Reset values
  localparam logic [7:0] RST_LOCK_CFG = 8'h00;
  localparam logic [7:0] RST_SYNC_DLY = 8'h00;
  localparam logic [7:0] RST_STAT_MON = 8'h00;

  // Consecutive in-window cycles needed for lock
  localparam logic [7:0] LOCK_CNT_SHORT = 8'h05;
  localparam logic [7:0] LOCK_CNT_MID   = 8'h40;
  localparam logic [7:0] LOCK_CNT_LONG  = 8'hFF;

  // Lock window of the high range, in picoseconds
  localparam logic [15:0] LOCK_WIN_HI_PS = 16'h0DAC;

  // Monitor thresholds and the cycle counts derived from them
  localparam longint unsigned SYS_CLK_HZ    = 125000000;
  localparam longint unsigned REF_THR_HI_HZ = 1020000;
  localparam longint unsigned REF_THR_LO_HZ = 6000;
  localparam logic [15:0] REFMON_HI_CYC = 16'(SYS_CLK_HZ / REF_THR_HI_HZ);
  localparam logic [15:0] REFMON_LO_CYC = 16'(SYS_CLK_HZ / REF_THR_LO_HZ);

  // Sync pin action on the reference and feedback counters
  typedef enum logic [1:0] {
    PLLDC_SYNC_NONE  = 2'h0,
    PLLDC_SYNC_ASYNC = 2'h1,
    PLLDC_SYNC_SYNC  = 2'h2,
    PLLDC_SYNC_IDLE  = 2'h3
  } plldc_sync_t;

  // Digital lock detector state
  typedef enum logic {
    PLLDC_UNLOCKED = 1'b0,
    PLLDC_LOCKED   = 1'b1
  } plldc_lock_t;

endpackage : plldc_pkg

// File: core/plldc_refmon.sv
// Frequency monitor for one clock input against a period limit
`timescale 1ns/1ps
module plldc_refmon (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        mon_pin_i,
  input  wire logic [15:0] limit_i,
  output logic             valid_o
);

  // All state of the monitor
  typedef struct packed {
    logic [1:0]  meta;
    logic        prev;
    logic [15:0] cnt;
    logic        valid;
  } plldc_refmon_t;

  plldc_refmon_t s_q;
  plldc_refmon_t s_d;
  logic          rise;

  // Rising edge seen on the second synchroniser stage only
  assign rise = s_q.meta[1] & ~s_q.prev;

  // Period count; valid when an edge comes before the limit
  always_comb begin
    s_d         = s_q;
    s_d.meta    = {s_q.meta[0], mon_pin_i};
    s_d.prev    = s_q.meta[1];
    if (rise) begin
      s_d.valid = (s_q.cnt < limit_i);
      s_d.cnt   = 16'h0000;
    end else if (s_q.cnt >= limit_i) begin
      s_d.valid = 1'b0; // Too slow or stopped
    end else begin
      s_d.cnt   = 16'(s_q.cnt + 16'h0001);
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign valid_o = s_q.valid;

endmodule : plldc_refmon

// File: core/plldc_top.sv
// Digital lock detector, counter sync control, status divider and monitors
//
// Summary of operation
// - Lock after 5, 64 or 255 unbroken in-window cycles per count field.
// - A cycle counts when edge time difference is below the window.
// - Once locked, stay locked until difference exceeds loss threshold.
// - Window select clear picks high range (3.5 ns), set picks low.
// - Disable bit set turns the lock detector off; clear runs it.
// - Sync field: 00/11 nothing, 01 asynchronous, 10 synchronous reset.
// - Reference and feedback path delay fields, both zero at reset.
// - Status divider bit set divides the status output by four.
// - Reference valid above 1.02 MHz, or above 6 kHz when bit set.
// - Threshold bit leaves the oscillator clock monitor unchanged.
// - Lock output pin shows the lock flag as a high-when-locked level.
`timescale 1ns/1ps
module plldc_top #(
  parameter logic [15:0] LOCK_WIN_LO_PS   = 16'h0400,
  parameter logic [15:0] UNLOCK_HI_PS     = 16'h1B58,
  parameter logic [15:0] UNLOCK_LO_PS     = 16'h0800,
  parameter logic [15:0] REFMON_LO_CYC    = plldc_pkg::REFMON_LO_CYC,
  parameter logic [15:0] REFMON_HI_CYC    = plldc_pkg::REFMON_HI_CYC,
  parameter logic [15:0] CLKMON_CYC       = plldc_pkg::REFMON_HI_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Register port
  input  wire logic [9:0]  reg_addr_i,
  input  wire logic [7:0]  reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic [7:0]       reg_rdata_o,
  // Phase detector comparison result
  input  wire logic        phase_cmp_i,
  input  wire logic [15:0] phase_err_ps_i,
  // Pins and status source
  input  wire logic        sync_pin_n_i,
  input  wire logic        reference_input_one_i,
  input  wire logic        reference_input_two_i,
  input  wire logic        clk_mon_pin_i,
  input  wire logic        status_src_i,
  output logic             lock_output_pin_o,
  output logic             digital_lock_flag_o,
  output logic             counter_areset_o,
  output logic             counter_sreset_o,
  output logic [2:0]       ref_delay_o,
  output logic [2:0]       fb_delay_o,
  output logic             ref_in_dc_offset_o,
  output logic             status_o,
  output logic             ref_one_valid_o,
  output logic             ref_two_valid_o,
  output logic             clk_valid_o
);

  // Parameter checks
  // A loss threshold at or below its window would remove the hysteresis
  if (UNLOCK_HI_PS <= plldc_pkg::LOCK_WIN_HI_PS) begin : g_chk_hi
    $error("Loss threshold must exceed the high range window");
  end
  if (UNLOCK_LO_PS <= LOCK_WIN_LO_PS) begin : g_chk_lo
    $error("Loss threshold must exceed the low range window");
  end
  if (REFMON_LO_CYC <= REFMON_HI_CYC) begin : g_chk_mon
    $error("Low monitor threshold must allow a longer period");
  end
  if (LOCK_WIN_LO_PS >= plldc_pkg::LOCK_WIN_HI_PS) begin : g_chk_win
    $error("Low range window must be narrower than the high range");
  end
  if (REFMON_HI_CYC == 16'h0000) begin : g_chk_ref
    $error("Reference monitor limit must be nonzero");
  end
  if (CLKMON_CYC == 16'h0000) begin : g_chk_clk
    $error("Clock monitor limit must be nonzero");
  end

  // All state of the block
  // The lock flag is stored beside the state so outputs come from a flop
  typedef struct packed {
    logic [7:0]            lock_cfg;
    logic [7:0]            sync_dly;
    logic [7:0]            stat_mon;
    logic [7:0]            rdata;
    plldc_pkg::plldc_lock_t lstate;
    logic [7:0]            run_cnt;
    logic                  lock_flag;
    logic                  lock_pin;
    logic [1:0]            sync_meta;
    logic                  sync_prev;
    logic                  areset;
    logic                  sreset;
    logic                  src_prev;
    logic [1:0]            div_cnt;
    logic                  status;
  } plldc_state_t;

  plldc_state_t           s_q;
  plldc_state_t           s_d;
  plldc_pkg::plldc_sync_t sync_mode;
  logic [1:0]             cnt_code;
  logic [7:0]             lock_target;
  logic [15:0]            win_ps;
  logic [15:0]            loss_ps;
  logic                   lock_dis;
  logic                   in_win;
  logic                   out_loss;
  logic                   sync_act;
  logic                   sync_fall;
  logic [15:0]            ref_limit;
  logic [2:0]             mon_pins;
  logic [2:0]             mon_valid;
  logic [15:0]            mon_limit [3];
  logic [7:0]             status_reg;

  // Field decode
  // Fields are read from the stored registers, not the write data
  assign cnt_code  = s_q.lock_cfg[plldc_pkg::LCK_CNT_LSB +: 2];
  assign lock_dis  = s_q.lock_cfg[plldc_pkg::LCK_DIS_BIT];
  assign sync_mode = plldc_pkg::plldc_sync_t'(
                       s_q.sync_dly[plldc_pkg::SYNC_MODE_LSB +: 2]);

  // Run length needed for lock
  always_comb begin
    case (cnt_code)
      2'h0:    lock_target = plldc_pkg::LOCK_CNT_SHORT;
      2'h2:    lock_target = plldc_pkg::LOCK_CNT_MID;
      default: lock_target = plldc_pkg::LOCK_CNT_LONG;
    endcase
  end

  // Window and loss threshold of the selected range
  always_comb begin
    if (s_q.lock_cfg[plldc_pkg::LCK_WIN_BIT]) begin
      win_ps  = LOCK_WIN_LO_PS;
      loss_ps = UNLOCK_LO_PS;
    end else begin
      win_ps  = plldc_pkg::LOCK_WIN_HI_PS;
      loss_ps = UNLOCK_HI_PS;
    end
  end

  // Comparison of the measured edge difference
  // Strict compares: an error equal to a limit neither counts nor drops
  assign in_win   = phase_err_ps_i < win_ps;
  assign out_loss = phase_err_ps_i > loss_ps;

  // Sync pin is active low; second stage only feeds the logic
  // A mode change while the pin is low gives no fall and no sreset pulse; mode 01 still drives areset from the level
  assign sync_act  = ~s_q.sync_meta[1];
  assign sync_fall = sync_act & ~s_q.sync_prev;

  // Reference monitor limit follows the threshold bit
  assign ref_limit = s_q.stat_mon[plldc_pkg::RMON_THR_BIT] ?
                     REFMON_LO_CYC : REFMON_HI_CYC;

  assign mon_pins = {clk_mon_pin_i, reference_input_two_i,
                     reference_input_one_i};
  assign mon_limit[0] = ref_limit;
  assign mon_limit[1] = ref_limit;
  assign mon_limit[2] = CLKMON_CYC;

  // One frequency monitor per watched clock input
  // The oscillator clock limit never follows the threshold bit
  for (genvar g = 0; g < 3; g++) begin : g_mon
    plldc_refmon u_mon (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .mon_pin_i (mon_pins[g]),
      .limit_i   (mon_limit[g]),
      .valid_o   (mon_valid[g])
    );
  end

  // Read-only view of the block state
  always_comb begin
    status_reg                           = 8'h00;
    status_reg[plldc_pkg::ST_LOCK_BIT]   = s_q.lock_flag;
    status_reg[plldc_pkg::ST_REFERENCE_INPUT_ONE_BIT]   = mon_valid[0];
    status_reg[plldc_pkg::ST_REFERENCE_INPUT_TWO_BIT]   = mon_valid[1];
    status_reg[plldc_pkg::ST_CLK_BIT]    = mon_valid[2];
    status_reg[plldc_pkg::ST_SYNC_BIT]   = sync_act;
  end

  // Next state of the whole block
  always_comb begin
    s_d = s_q;

    // Register writes
    // Writes to the status offset or unmapped offsets are dropped
    if (reg_wr_i) begin
      case (reg_addr_i)
        plldc_pkg::OFF_LOCK_CFG: begin
          s_d.lock_cfg = reg_wdata_i;
        end
        plldc_pkg::OFF_SYNC_DLY: begin
          s_d.sync_dly = reg_wdata_i;
        end
        plldc_pkg::OFF_STAT_MON: begin
          s_d.stat_mon = reg_wdata_i;
        end
        default: begin
          s_d.stat_mon = s_q.stat_mon;
        end
      endcase
    end

    // Register reads, answered one cycle later
    // Unmapped reads return zero so no stale data reaches software
    if (reg_rd_i) begin
      case (reg_addr_i)
        plldc_pkg::OFF_LOCK_CFG: s_d.rdata = s_q.lock_cfg;
        plldc_pkg::OFF_SYNC_DLY: s_d.rdata = s_q.sync_dly;
        plldc_pkg::OFF_STAT_MON: s_d.rdata = s_q.stat_mon;
        plldc_pkg::OFF_STATUS:   s_d.rdata = status_reg;
        default:                 s_d.rdata = 8'h00;
      endcase
    end

    // Digital lock detector
    // The run count clears on lock, so a later loss restarts at zero
    if (lock_dis) begin
      s_d.lstate  = plldc_pkg::PLLDC_UNLOCKED;
      s_d.run_cnt = 8'h00;
    end else if (phase_cmp_i) begin
      case (s_q.lstate)
        plldc_pkg::PLLDC_UNLOCKED: begin
          if (!in_win) begin
            s_d.run_cnt = 8'h00;
          end else if (8'(s_q.run_cnt + 8'h01) >= lock_target) begin
            s_d.lstate  = plldc_pkg::PLLDC_LOCKED;
            s_d.run_cnt = 8'h00;
          end else begin
            s_d.run_cnt = 8'(s_q.run_cnt + 8'h01);
          end
        end
        plldc_pkg::PLLDC_LOCKED: begin
          if (out_loss) begin
            s_d.lstate  = plldc_pkg::PLLDC_UNLOCKED;
            s_d.run_cnt = 8'h00;
          end
        end
        default: begin
          s_d.lstate  = plldc_pkg::PLLDC_UNLOCKED;
          s_d.run_cnt = 8'h00;
        end
      endcase
    end
    s_d.lock_flag = (s_d.lstate == plldc_pkg::PLLDC_LOCKED);
    s_d.lock_pin  = s_d.lock_flag;

    // Sync pin action on the divider counters
    s_d.sync_meta = {s_q.sync_meta[0], sync_pin_n_i};
    s_d.sync_prev = sync_act;
    s_d.areset    = 1'b0;
    s_d.sreset    = 1'b0;
    case (sync_mode)
      plldc_pkg::PLLDC_SYNC_ASYNC: s_d.areset = sync_act;
      plldc_pkg::PLLDC_SYNC_SYNC:  s_d.sreset = sync_fall;
      default: begin
        s_d.areset = 1'b0;
        s_d.sreset = 1'b0;
      end
    endcase

    // Status output, optionally divided by four
    // Bit 1 of the edge count toggles on every second source rise
    s_d.src_prev = status_src_i;
    if (status_src_i && !s_q.src_prev) begin
      s_d.div_cnt = 2'(s_q.div_cnt + 2'h1);
    end
    if (s_q.stat_mon[plldc_pkg::STDIV_BIT]) begin
      s_d.status = s_q.div_cnt[1];
    end else begin
      s_d.status = status_src_i;
    end
  end

  // State register
  // The synchroniser resets to the idle pin level to avoid a false fall
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q           <= '0;
      s_q.lock_cfg  <= plldc_pkg::RST_LOCK_CFG;
      s_q.sync_dly  <= plldc_pkg::RST_SYNC_DLY;
      s_q.stat_mon  <= plldc_pkg::RST_STAT_MON;
      s_q.sync_meta <= 2'h3;
      s_q.sync_prev <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state register and the monitor state registers
  // The dc offset bit is only stored; nothing here acts on it
  assign reg_rdata_o         = s_q.rdata;
  assign lock_output_pin_o   = s_q.lock_pin;
  assign digital_lock_flag_o = s_q.lock_flag;
  assign counter_areset_o    = s_q.areset;
  assign counter_sreset_o    = s_q.sreset;
  assign ref_delay_o         = s_q.sync_dly[plldc_pkg::RDLY_LSB +: 3];
  assign fb_delay_o          = s_q.sync_dly[plldc_pkg::NDLY_LSB +: 3];
  assign ref_in_dc_offset_o  = s_q.lock_cfg[plldc_pkg::LCK_DCOFS_BIT];
  assign status_o            = s_q.status;
  assign ref_one_valid_o     = mon_valid[0];
  assign ref_two_valid_o     = mon_valid[1];
  assign clk_valid_o         = mon_valid[2];

endmodule : plldc_top

// File: tb/plldc_monitor.sv
// Checker of the lock detector, sync, delay and status outputs
`timescale 1ns/1ps
module plldc_monitor #(
  parameter logic [15:0] LOCK_WIN_LO_PS = 16'h0400,
  parameter logic [15:0] UNLOCK_HI_PS   = 16'h1B58,
  parameter logic [15:0] UNLOCK_LO_PS   = 16'h0800
) (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic [9:0]  reg_addr_i,
  input wire logic [7:0]  reg_wdata_i,
  input wire logic        reg_wr_i,
  input wire logic        phase_cmp_i,
  input wire logic [15:0] phase_err_ps_i,
  input wire logic        sync_pin_n_i,
  input wire logic        status_src_i,
  input wire logic        lock_output_pin_o,
  input wire logic        digital_lock_flag_o,
  input wire logic        counter_areset_o,
  input wire logic        counter_sreset_o,
  input wire logic [2:0]  ref_delay_o,
  input wire logic [2:0]  fb_delay_o,
  input wire logic        status_o
);
  logic [7:0]  cfg_q, sd_q, sm_q, run_q, need;
  logic [15:0] loss;
  logic        inw;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Window, loss threshold and lock count from the tracked settings
  always_comb begin
    inw = phase_err_ps_i < (cfg_q[4] ? LOCK_WIN_LO_PS
                                     : plldc_pkg::LOCK_WIN_HI_PS);
    loss = cfg_q[4] ? UNLOCK_LO_PS : UNLOCK_HI_PS;
    need = cfg_q[6:5] == 2'h0 ? 8'h05 : cfg_q[6:5] == 2'h2 ? 8'h40 : 8'hFF;
  end
  // Shadow registers and the unbroken in-window run
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_q <= 8'h00;
      sd_q  <= 8'h00;
      sm_q  <= 8'h00;
      run_q <= 8'h00;
    end else begin
      if (reg_wr_i && reg_addr_i == plldc_pkg::OFF_LOCK_CFG)
        cfg_q <= reg_wdata_i;
      if (reg_wr_i && reg_addr_i == plldc_pkg::OFF_SYNC_DLY)
        sd_q <= reg_wdata_i;
      if (reg_wr_i && reg_addr_i == plldc_pkg::OFF_STAT_MON)
        sm_q <= reg_wdata_i;
      if (cfg_q[3]) run_q <= 8'h00;
      else if (phase_cmp_i) run_q <= !inw ? 8'h00 :
                                     run_q == 8'hFF ? run_q : run_q + 8'h01;
    end
  end
  a_pin_mirror: assert property (
    lock_output_pin_o == digital_lock_flag_o)
    else $error("lock pin differs from lock flag");
  a_lock_early: assert property (
    $rose(digital_lock_flag_o) |-> run_q >= need)
    else $error("lock flag rose before the required run");
  a_lock_exact: assert property (
    phase_cmp_i && inw && !cfg_q[3] && !reg_wr_i &&
    run_q == need - 8'h01 |=> digital_lock_flag_o)
    else $error("lock flag missing after the required run");
  a_lock_loss: assert property (phase_cmp_i && phase_err_ps_i > loss
    |=> !digital_lock_flag_o)
    else $error("lock flag kept past the loss threshold");
  a_lock_hold: assert property (
    digital_lock_flag_o && !cfg_q[3] && !reg_wr_i &&
    (!phase_cmp_i || phase_err_ps_i <= loss) |=> digital_lock_flag_o)
    else $error("lock flag dropped inside the loss threshold");
  a_dis_unlock: assert property (
    cfg_q[3] && $past(cfg_q[3]) |-> !digital_lock_flag_o)
    else $error("lock flag high while disabled");
  a_sync_async: assert property ($fell(sync_pin_n_i) && sd_q[7:6] == 2'h1
    |-> ##[1:5] counter_areset_o)
    else $error("no asynchronous counter reset on sync");
  a_sreset_mode: assert property (counter_sreset_o |-> sd_q[7:6] == 2'h2
    ##1 !counter_sreset_o)
    else $error("synchronous counter reset in wrong mode or too long");
  a_delay_fields: assert property ($stable(sd_q) && !$past(rst_i)
    |-> {ref_delay_o, fb_delay_o} == sd_q[5:0])
    else $error("path delay outputs differ from register");
  a_status_plain: assert property (
    !sm_q[7] && $stable(sm_q) && !$past(rst_i)
    |-> status_o == $past(status_src_i))
    else $error("undivided status output does not follow source");
  c_lock: cover property ($rose(digital_lock_flag_o));
  c_unlock: cover property ($fell(digital_lock_flag_o));
  c_areset: cover property (counter_areset_o);
  c_sreset: cover property (counter_sreset_o);
endmodule : plldc_monitor

bind plldc_top plldc_monitor #(
  .LOCK_WIN_LO_PS(LOCK_WIN_LO_PS),
  .UNLOCK_HI_PS(UNLOCK_HI_PS),
  .UNLOCK_LO_PS(UNLOCK_LO_PS)
) plldc_monitor_i (.clk_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
  .phase_cmp_i, .phase_err_ps_i, .sync_pin_n_i, .status_src_i,
  .lock_output_pin_o, .digital_lock_flag_o, .counter_areset_o,
  .counter_sreset_o, .ref_delay_o, .fb_delay_o, .status_o);

// File: tb/tb_top.sv
// Self-checking bench for the lock detector block
`timescale 1ns/1ps
module tb_top;
  logic clk_i = 1'b0, rst_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
  logic [9:0] reg_addr_i = 10'h000;
  logic [7:0] reg_wdata_i = 8'h00, reg_rdata_o, d;
  logic [15:0] phase_err_ps_i = 16'h0000;
  logic phase_cmp_i = 1'b0, sync_pin_n_i = 1'b1, status_src_i = 1'b0;
  logic reference_input_one_i = 1'b0, reference_input_two_i = 1'b0;
  logic clk_mon_pin_i = 1'b0, sa, ss, p;
  logic lock_output_pin_o, digital_lock_flag_o, counter_areset_o;
  logic counter_sreset_o, ref_in_dc_offset_o, status_o;
  logic ref_one_valid_o, ref_two_valid_o, clk_valid_o;
  logic [2:0] ref_delay_o, fb_delay_o;
  int errors = 0, num_checks = 0, cyc = 0, n, t, cper = 160;

  plldc_top #(.REFMON_LO_CYC(16'h00C8)) plldc_top_i (.clk_i, .rst_i,
    .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
    .phase_cmp_i, .phase_err_ps_i, .sync_pin_n_i, .reference_input_one_i,
    .reference_input_two_i, .clk_mon_pin_i, .status_src_i,
    .lock_output_pin_o, .digital_lock_flag_o, .counter_areset_o,
    .counter_sreset_o, .ref_delay_o, .fb_delay_o, .ref_in_dc_offset_o,
    .status_o, .ref_one_valid_o, .ref_two_valid_o, .clk_valid_o);

  // Clock of 8 ns period
  initial begin
    forever #4 clk_i = ~clk_i;
  end
  // Monitored pins: 40-cycle and 160-cycle pulse trains
  always @(negedge clk_i) begin
    cyc <= cyc + 1;
    reference_input_one_i <= (cyc % 40) < 2;
    reference_input_two_i <= (cyc % 160) < 2;
    clk_mon_pin_i <= (cyc % cper) < 2;
  end

  task automatic chk(string nm, logic [15:0] s, logic [15:0] e);
    num_checks++;
    if (s !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic wr(logic [9:0] a, logic [7:0] v);
    reg_addr_i = a;
    reg_wdata_i = v;
    reg_wr_i = 1'b1;
    @(negedge clk_i);
    reg_wr_i = 1'b0;
    @(negedge clk_i);
  endtask : wr

  task automatic rd(logic [9:0] a, logic [7:0] e);
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    @(negedge clk_i);
    reg_rd_i = 1'b0;
    chk("rdata", reg_rdata_o, e);
    @(negedge clk_i);
  endtask : rd

  // Phase comparisons with random error in a range, then one idle cycle
  task automatic pc(int cnt, int lo, int hi);
    repeat (cnt) begin
      phase_cmp_i = 1'b1;
      phase_err_ps_i = 16'(lo + $urandom % (hi - lo + 1));
      @(negedge clk_i);
    end
    phase_cmp_i = 1'b0;
    @(negedge clk_i);
  endtask : pc

  function automatic int need(logic [1:0] c);
    return c == 2'h0 ? 5 : c == 2'h2 ? 64 : 255;
  endfunction : need

  task automatic test_done();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : test_done

  // Watchdog
  initial begin
    repeat (60000) @(posedge clk_i);
    errors++;
    test_done();
  end

  // Main sequence
  initial begin
    void'($urandom(32'hFCF5DE57));
    repeat (5) @(negedge clk_i);
    rst_i = 1'b0;
    rd(plldc_pkg::OFF_LOCK_CFG, 8'h00);
    rd(plldc_pkg::OFF_SYNC_DLY, 8'h00);
    rd(plldc_pkg::OFF_STAT_MON, 8'h00);
    rd(10'h155, 8'h00);
    chk("flag", digital_lock_flag_o, 1'b0);
    $display("reset test done");
    repeat (4) begin
      d = 8'($urandom) & 8'h3F;
      wr(plldc_pkg::OFF_SYNC_DLY, d);
      rd(plldc_pkg::OFF_SYNC_DLY, d);
      chk("delays", {ref_delay_o, fb_delay_o}, d[5:0]);
    end
    $display("delay test done");
    for (int c = 0; c < 4; c++) begin
      n = need(2'(c));
      wr(plldc_pkg::OFF_LOCK_CFG, 8'(c << 5));
      pc(1, 7500, 9000);
      pc(n - 1, 0, 3499);
      chk("early", digital_lock_flag_o, 1'b0);
      pc(1, 3500, 3500);
      pc(n - 1, 0, 3499);
      chk("broken", digital_lock_flag_o, 1'b0);
      pc(1, 0, 3499);
      chk("lock", digital_lock_flag_o, 1'b1);
      chk("pin", lock_output_pin_o, 1'b1);
    end
    pc(3, 3500, 7000);
    chk("hold", digital_lock_flag_o, 1'b1);
    pc(1, 7001, 7001);
    chk("loss", digital_lock_flag_o, 1'b0);
    wr(plldc_pkg::OFF_LOCK_CFG, 8'h10);
    pc(5, 1024, 3499);
    chk("low window", digital_lock_flag_o, 1'b0);
    pc(5, 0, 1023);
    chk("low lock", digital_lock_flag_o, 1'b1);
    rd(plldc_pkg::OFF_STATUS, 8'h03);
    wr(plldc_pkg::OFF_LOCK_CFG, 8'h18);
    chk("disabled", digital_lock_flag_o, 1'b0);
    pc(8, 0, 1023);
    chk("disabled run", digital_lock_flag_o, 1'b0);
    $display("lock test done");
    for (int m = 0; m < 4; m++) begin
      wr(plldc_pkg::OFF_SYNC_DLY, 8'(m << 6));
      sa = 1'b0;
      ss = 1'b0;
      sync_pin_n_i = 1'b0;
      repeat (8) begin
        @(negedge clk_i);
        sa = sa | counter_areset_o;
        ss = ss | counter_sreset_o;
      end
      rd(plldc_pkg::OFF_STATUS, 8'h12);
      sync_pin_n_i = 1'b1;
      repeat (6) @(negedge clk_i);
      chk("areset", sa, m == 1);
      chk("sreset", ss, m == 2);
    end
    $display("sync test done");
    repeat (8) begin
      status_src_i = 1'($urandom);
      @(negedge clk_i);
      chk("status", status_o, status_src_i);
    end
    status_src_i = 1'b0;
    wr(plldc_pkg::OFF_STAT_MON, 8'h80);
    t = 0;
    p = status_o;
    for (int k = 0; k < 40; k++) begin
      status_src_i = (k < 32) && k[1];
      @(negedge clk_i);
      t += int'(status_o !== p);
      p = status_o;
    end
    chk("div4", 16'(t), 16'h0004);
    $display("status test done");
    wr(plldc_pkg::OFF_STAT_MON, 8'h00);
    repeat (500) @(negedge clk_i);
    chk("reference_input_one", ref_one_valid_o, 1'b1);
    chk("reference_input_two high", ref_two_valid_o, 1'b0);
    chk("clk high", clk_valid_o, 1'b0);
    wr(plldc_pkg::OFF_STAT_MON, 8'h40);
    repeat (500) @(negedge clk_i);
    chk("reference_input_two low", ref_two_valid_o, 1'b1);
    chk("clk low", clk_valid_o, 1'b0);
    rd(plldc_pkg::OFF_STATUS, 8'h06);
    cper = 40;
    repeat (500) @(negedge clk_i);
    chk("clk fast", clk_valid_o, 1'b1);
    rd(plldc_pkg::OFF_STATUS, 8'h0E);
    $display("monitor test done");
    wr(plldc_pkg::OFF_LOCK_CFG, 8'h80);
    chk("dc offset", ref_in_dc_offset_o, 1'b1);
    rst_i = 1'b1;
    repeat (2) @(negedge clk_i);
    rst_i = 1'b0;
    rd(plldc_pkg::OFF_LOCK_CFG, 8'h00);
    rd(plldc_pkg::OFF_SYNC_DLY, 8'h00);
    rd(plldc_pkg::OFF_STAT_MON, 8'h00);
    chk("dc offset clear", ref_in_dc_offset_o, 1'b0);
    $display("mid-run reset test done");
    test_done();
  end
endmodule : tb_top
